// ==== hdl/fpbfm_defs.vh ====
`ifndef FPBFM_DEFS_VH
`define FPBFM_DEFS_VH

// =====================================================================
// storage geometry
`define FPBFM_WIDTH 36
`define FPBFM_DEPTH 7'h40
`define FPBFM_PTR_W 7

// =====================================================================
// fill offset presets, indexed by {offset_sel_hi, offset_sel_lo}
`define FPBFM_OFS_HH 5'h10
`define FPBFM_OFS_HL 5'h0c
`define FPBFM_OFS_LH 5'h08
`define FPBFM_OFS_LL 5'h04

// =====================================================================
// port b bus size codes, {size_sel_hi, size_sel_lo}
`define FPBFM_SIZE_LONG 2'b00
`define FPBFM_SIZE_BYTE 2'b01
`define FPBFM_SIZE_WORD 2'b10
`define FPBFM_SIZE_MAIL 2'b11

// =====================================================================
// timing: skew windows in ns and in clk_i cycles at 25 MHz (40 ns)
`define FPBFM_CLK_PERIOD_NS 40
`define FPBFM_SKEW_ONE_NS 5
`define FPBFM_SKEW_TWO_NS 5
`define FPBFM_SKEW_ONE_CYC ((`FPBFM_SKEW_ONE_NS + `FPBFM_CLK_PERIOD_NS - 1) / `FPBFM_CLK_PERIOD_NS)
`define FPBFM_SKEW_TWO_CYC ((`FPBFM_SKEW_TWO_NS + `FPBFM_CLK_PERIOD_NS - 1) / `FPBFM_CLK_PERIOD_NS)

// =====================================================================
// wishbone register map (byte addresses)
`define FPBFM_REG_STATUS 4'h0
`define FPBFM_REG_CTRL 4'h4
`define FPBFM_CTRL_SOFT_RST 0
`define FPBFM_CTRL_RESET 1'h0

`endif

// ==== hdl/fpbfm_top.v ====
// Function
// - port b enabled read with a size select low pops fifo into output register
// - port b enabled write with both size selects high stores bus into b-to-a mailbox
// - driven port b shows fifo output register, or a-to-b mailbox when both sizes high
// - space flag low means full; fifo writes are ignored then
// - write pointer advances per write; comparator detects full levels
// - space flag rises on second port a edge after a read frees room
// - a port a edge in the same cycle as the read does not count
// - low-fill flag on port b: low at offset or fewer words, high above
// - low-fill flag rises on second port b edge after the filling write
// - high-fill flag on port a: low at 64 minus offset or more words
// - high-fill flag rises on second port a edge after the draining read
// - fill offset loaded on the first cycle after device reset release from four presets
// - port a enabled write with mailbox select stores bus into a-to-b mailbox
// - mailbox write drives its flag low; further writes ignored while low
// - a-to-b mailbox flag set high by port b mailbox read
// - b-to-a mailbox flag set high by port a mailbox read
// - mailbox reads never alter contents
// - fifo reads on port b in 36, 18 or 9 bit lanes, big or little endian
// - size and endian selects sampled each port b edge unless both sizes high, applied from the next
// - memory moves whole long words; sizing after memory, never for mailboxes
// - port b data driven only when select and write-not-read are both low
// - data-available flag low means empty; fifo reads that need a new long word are ignored then
// - reset clears pointers, sets flag levels; space flag rises two port a edges later
// - offset selects decode to 16, 12, 8 or 4 at reset release
`timescale 1ns/1ps
`include "fpbfm_defs.vh"

module fpbfm_top (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // port a
  input wire port_a_clock_i,
  input wire port_a_select_n_i,
  input wire port_a_write_not_read_i,
  input wire port_a_enable_i,
  input wire port_a_mailbox_sel_i,
  input wire [35:0] port_a_data_i,
  output reg [35:0] port_a_data_o,
  output reg port_a_data_oe_n_o,
  // port b
  input wire port_b_clock_i,
  input wire port_b_select_n_i,
  input wire port_b_write_not_read_i,
  input wire port_b_enable_i,
  input wire port_b_size_sel_lo_i,
  input wire port_b_size_sel_hi_i,
  input wire big_endian_sel_n_i,
  input wire [35:0] port_b_data_i,
  output reg [35:0] port_b_data_o,
  output reg port_b_data_oe_n_o,
  // offset straps
  input wire offset_sel_lo_i,
  input wire offset_sel_hi_i,
  // flags
  output reg space_flag_n_o,
  output reg data_avail_flag_n_o,
  output reg low_fill_flag_n_o,
  output reg high_fill_flag_n_o,
  output reg a_to_b_mailbox_flag_n_o,
  output reg b_to_a_mailbox_flag_n_o
);

  // =====================================================================
  // storage and state
  reg [35:0] mem [0:63];
  reg [35:0] a_to_b_mailbox;
  reg [35:0] b_to_a_mailbox;
  reg [6:0] wr_ptr;
  reg [6:0] rd_ptr;
  reg [6:0] wr_ptr_sync;
  reg [6:0] rd_ptr_sync;
  reg [4:0] fill_offset;
  reg offset_pending;
  reg space_ready;
  reg a_clk_d;
  reg b_clk_d;
  reg soft_rst;
  reg [35:0] fifo_out;
  reg [35:0] word_hold;
  reg [1:0] size_q;
  reg big_q;
  reg [1:0] piece_idx;
  reg [1:0] pieces_left;
  reg [1:0] size_cur_word;

  // =====================================================================
  // reset and port clock edges
  // port clocks are sampled pins; an edge is a one-cycle enable
  wire dev_rst = rst_i | soft_rst;
  wire a_edge = port_a_clock_i & ~a_clk_d;
  wire b_edge = port_b_clock_i & ~b_clk_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      // follow the pins in reset so a high pin gives no false edge at release
      a_clk_d <= port_a_clock_i;
      b_clk_d <= port_b_clock_i;
    end else begin
      a_clk_d <= port_a_clock_i;
      b_clk_d <= port_b_clock_i;
    end
  end

  // =====================================================================
  // port decode
  wire a_sel = ~port_a_select_n_i & port_a_enable_i;
  wire a_fifo_wr = a_sel & port_a_write_not_read_i & ~port_a_mailbox_sel_i;
  wire a_mail_wr = a_sel & port_a_write_not_read_i & port_a_mailbox_sel_i;
  wire a_mail_rd = a_sel & ~port_a_write_not_read_i & port_a_mailbox_sel_i;
  wire b_sel = ~port_b_select_n_i & port_b_enable_i;
  wire b_mail_pins = port_b_size_sel_hi_i & port_b_size_sel_lo_i;
  wire b_fifo_rd = b_sel & ~port_b_write_not_read_i & ~b_mail_pins;
  wire b_mail_wr = b_sel & port_b_write_not_read_i & b_mail_pins;
  wire b_mail_rd = b_sel & ~port_b_write_not_read_i & b_mail_pins;

  // =====================================================================
  // write side (port a domain)
  wire wr_take = a_edge & a_fifo_wr & space_flag_n_o;
  wire [6:0] wr_ptr_next = wr_ptr + {6'h00, wr_take};
  // fill seen by port a uses the read pointer after one sync stage
  wire [6:0] fill_a = wr_ptr_next - rd_ptr_sync;
  wire [6:0] high_mark = `FPBFM_DEPTH - {2'b00, fill_offset};

  always @(posedge clk_i) begin
    if (wr_take) begin
      mem[wr_ptr[5:0]] <= port_a_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (dev_rst) begin
      wr_ptr <= 7'h00;
      rd_ptr_sync <= 7'h00;
      space_ready <= 1'b0;
      space_flag_n_o <= 1'b0;
      high_fill_flag_n_o <= 1'b1;
    end else if (a_edge) begin
      wr_ptr <= wr_ptr_next;
      // the current edge samples the pointer before this cycle's read
      rd_ptr_sync <= rd_ptr;
      space_ready <= 1'b1;
      // the flag register is the second stage: rises two edges after a read
      space_flag_n_o <= space_ready & (fill_a != `FPBFM_DEPTH);
      high_fill_flag_n_o <= (fill_a < high_mark);
    end
  end

  // =====================================================================
  // read side (port b domain)
  wire new_word = (pieces_left == 2'h0) || (size_q != size_cur_word);
  wire rd_pop = b_edge & b_fifo_rd & new_word & data_avail_flag_n_o;
  wire rd_take = b_edge & b_fifo_rd & (~new_word | data_avail_flag_n_o);
  wire [6:0] rd_ptr_next = rd_ptr + {6'h00, rd_pop};
  wire [6:0] fill_b = wr_ptr_sync - rd_ptr_next;
  wire [35:0] cur_word = new_word ? mem[rd_ptr[5:0]] : word_hold;
  wire [1:0] cur_idx = new_word ? 2'h0 : piece_idx;

  reg [35:0] next_fifo_out;
  reg [1:0] next_pieces;
  reg [1:0] lane;
  reg [8:0] byte_piece;
  reg [17:0] word_piece;

  // width matching after the memory; big endian takes the high lanes first
  always @* begin
    next_fifo_out = fifo_out;
    next_pieces = 2'h0;
    lane = 2'h0;
    byte_piece = 9'h000;
    word_piece = 18'h00000;
    case (size_q)
      `FPBFM_SIZE_WORD: begin
        next_pieces = 2'h1;
        word_piece = (big_q ^ cur_idx[0]) ? cur_word[35:18] : cur_word[17:0];
        if (big_q) begin
          next_fifo_out = {word_piece, fifo_out[17:0]};
        end else begin
          next_fifo_out = {fifo_out[35:18], word_piece};
        end
      end
      `FPBFM_SIZE_BYTE: begin
        next_pieces = 2'h3;
        lane = big_q ? (2'h3 - cur_idx) : cur_idx;
        case (lane)
          2'h0: byte_piece = cur_word[8:0];
          2'h1: byte_piece = cur_word[17:9];
          2'h2: byte_piece = cur_word[26:18];
          default: byte_piece = cur_word[35:27];
        endcase
        if (big_q) begin
          next_fifo_out = {byte_piece, fifo_out[26:0]};
        end else begin
          next_fifo_out = {fifo_out[35:9], byte_piece};
        end
      end
      default: begin
        next_pieces = 2'h0;
        next_fifo_out = cur_word;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (dev_rst) begin
      rd_ptr <= 7'h00;
      wr_ptr_sync <= 7'h00;
      size_q <= `FPBFM_SIZE_LONG;
      big_q <= 1'b0;
      size_cur_word <= `FPBFM_SIZE_LONG;
      pieces_left <= 2'h0;
      piece_idx <= 2'h0;
      word_hold <= 36'h000000000;
      fifo_out <= 36'h000000000;
      data_avail_flag_n_o <= 1'b0;
      low_fill_flag_n_o <= 1'b0;
    end else if (b_edge) begin
      // a mailbox access keeps the previous bus size
      if (!b_mail_pins) begin
        size_q <= {port_b_size_sel_hi_i, port_b_size_sel_lo_i};
        big_q <= ~big_endian_sel_n_i;
      end
      wr_ptr_sync <= wr_ptr;
      rd_ptr <= rd_ptr_next;
      // a new size forces a fresh long word; unread pieces are lost
      if (rd_pop) begin
        word_hold <= cur_word;
        size_cur_word <= size_q;
        pieces_left <= next_pieces;
        piece_idx <= 2'h1;
        fifo_out <= next_fifo_out;
      end else if (rd_take) begin
        pieces_left <= pieces_left - 2'h1;
        piece_idx <= piece_idx + 2'h1;
        fifo_out <= next_fifo_out;
      end
      data_avail_flag_n_o <= (fill_b != 7'h00);
      low_fill_flag_n_o <= (fill_b > {2'b00, fill_offset});
    end
  end

  // =====================================================================
  // fill offset, caught on the first cycle after reset release
  always @(posedge clk_i) begin
    if (dev_rst) begin
      offset_pending <= 1'b1;
      fill_offset <= `FPBFM_OFS_LL;
    end else if (offset_pending) begin
      offset_pending <= 1'b0;
      case ({offset_sel_hi_i, offset_sel_lo_i})
        2'b11: fill_offset <= `FPBFM_OFS_HH;
        2'b10: fill_offset <= `FPBFM_OFS_HL;
        2'b01: fill_offset <= `FPBFM_OFS_LH;
        default: fill_offset <= `FPBFM_OFS_LL;
      endcase
    end
  end

  // =====================================================================
  // mailboxes; contents change only on an accepted write
  always @(posedge clk_i) begin
    if (dev_rst) begin
      a_to_b_mailbox <= 36'h000000000;
      a_to_b_mailbox_flag_n_o <= 1'b1;
    end else begin
      // a write in the same cycle as a read leaves the flag low
      if (a_edge & a_mail_wr & a_to_b_mailbox_flag_n_o) begin
        a_to_b_mailbox <= port_a_data_i;
        a_to_b_mailbox_flag_n_o <= 1'b0;
      end else if (b_edge & b_mail_rd) begin
        a_to_b_mailbox_flag_n_o <= 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (dev_rst) begin
      b_to_a_mailbox <= 36'h000000000;
      b_to_a_mailbox_flag_n_o <= 1'b1;
    end else begin
      if (b_edge & b_mail_wr & b_to_a_mailbox_flag_n_o) begin
        b_to_a_mailbox <= port_b_data_i;
        b_to_a_mailbox_flag_n_o <= 1'b0;
      end else if (a_edge & a_mail_rd) begin
        b_to_a_mailbox_flag_n_o <= 1'b1;
      end
    end
  end

  // =====================================================================
  // data pin drivers, registered one clk_i after the controls
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_a_data_o <= 36'h000000000;
      port_a_data_oe_n_o <= 1'b1;
      port_b_data_o <= 36'h000000000;
      port_b_data_oe_n_o <= 1'b1;
    end else begin
      port_a_data_o <= b_to_a_mailbox;
      port_a_data_oe_n_o <= port_a_select_n_i | port_a_write_not_read_i;
      port_b_data_o <= b_mail_pins ? a_to_b_mailbox : fifo_out;
      port_b_data_oe_n_o <= port_b_select_n_i | port_b_write_not_read_i;
    end
  end

  // =====================================================================
  // wishbone slave: status and control
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [31:0] status_word = {9'h000, fill_b, 3'h0, fill_offset, 2'h0,
    b_to_a_mailbox_flag_n_o, a_to_b_mailbox_flag_n_o, high_fill_flag_n_o,
    low_fill_flag_n_o, data_avail_flag_n_o, space_flag_n_o};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      soft_rst <= `FPBFM_CTRL_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req) begin
        case (wb_adr_i)
          `FPBFM_REG_STATUS: wb_dat_o <= status_word;
          `FPBFM_REG_CTRL: wb_dat_o <= {31'h00000000, soft_rst};
          default: wb_dat_o <= 32'h00000000;
        endcase
        if (wb_we_i && wb_sel_i[0] && (wb_adr_i == `FPBFM_REG_CTRL)) begin
          soft_rst <= wb_dat_i[`FPBFM_CTRL_SOFT_RST];
        end
      end
    end
  end

endmodule // fpbfm_top

// ==== verif/fpbfm_port_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// free-running port clocks of the two far-side masters
module fpbfm_port_model (
  // system clock
  input wire clk_i,
  // port clocks
  output reg port_a_clock_o = 1'b0,
  output reg port_b_clock_o = 1'b0
);
  reg [1:0] a_cnt = 2'h0;
  reg [2:0] b_cnt = 3'h0;
  // unequal periods so a and b edges slide against each other
  always @(posedge clk_i) begin
    a_cnt <= a_cnt + 2'h1;
    b_cnt <= (b_cnt == 3'h5) ? 3'h0 : b_cnt + 3'h1;
    port_a_clock_o <= a_cnt[1];
    port_b_clock_o <= (b_cnt > 3'h2);
  end
endmodule // fpbfm_port_model

// ==== verif/fpbfm_top_sva.sv ====
`timescale 1ns/1ps
// =====================================================================
// port-level checker
module fpbfm_top_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // ports
  input wire port_a_clock_i,
  input wire port_a_select_n_i,
  input wire port_a_write_not_read_i,
  input wire port_a_enable_i,
  input wire port_a_mailbox_sel_i,
  input wire port_b_clock_i,
  input wire port_b_select_n_i,
  input wire port_b_write_not_read_i,
  input wire port_b_enable_i,
  input wire port_b_size_sel_lo_i,
  input wire port_b_size_sel_hi_i,
  input wire port_b_data_oe_n_o,
  // flags
  input wire space_flag_n_o,
  input wire data_avail_flag_n_o,
  input wire low_fill_flag_n_o,
  input wire high_fill_flag_n_o,
  input wire a_to_b_mailbox_flag_n_o,
  input wire b_to_a_mailbox_flag_n_o
);
  reg a_q;
  reg b_q;
  wire a_r = port_a_clock_i & ~a_q;
  wire b_r = port_b_clock_i & ~b_q;
  wire a_e = a_r & ~port_a_select_n_i & port_a_enable_i & port_a_mailbox_sel_i;
  wire b_e = b_r & ~port_b_select_n_i & port_b_enable_i & port_b_size_sel_lo_i
    & port_b_size_sel_hi_i;
  wire a_w = port_a_write_not_read_i;
  wire b_w = port_b_write_not_read_i;
  always @(posedge clk_i) begin
    a_q <= port_a_clock_i;
    b_q <= port_b_clock_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // =====================================================================
  // assertions; two-cycle slack covers an internally registered pin edge
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_unmapped_zero: assert property (wb_ack_o && wb_adr_i != 4'h0 && wb_adr_i != 4'h4
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_oe_follow: assert property (port_b_data_oe_n_o == $past(port_b_select_n_i | b_w))
    else $error("port b drive wrong");
  a_empty_low: assert property (!data_avail_flag_n_o |-> !low_fill_flag_n_o)
    else $error("low fill high while empty");
  a_a_to_b_mailbox_flag_n_set: assert property ($rose(a_to_b_mailbox_flag_n_o)
    |-> $past(b_e & ~b_w) || $past(b_e & ~b_w, 2)) else $error("a-to-b flag rose early");
  a_a_to_b_mailbox_flag_n_clr: assert property ($fell(a_to_b_mailbox_flag_n_o)
    |-> $past(a_e & a_w) || $past(a_e & a_w, 2)) else $error("a-to-b flag fell early");
  a_b_to_a_mailbox_flag_n_set: assert property ($rose(b_to_a_mailbox_flag_n_o)
    |-> $past(a_e & ~a_w) || $past(a_e & ~a_w, 2)) else $error("b-to-a flag rose early");
  a_b_to_a_mailbox_flag_n_clr: assert property ($fell(b_to_a_mailbox_flag_n_o)
    |-> $past(b_e & b_w) || $past(b_e & b_w, 2)) else $error("b-to-a flag fell early");
  a_lowfill_sync: assert property ($changed(low_fill_flag_n_o)
    |-> $past(b_r) || $past(b_r, 2)) else $error("low fill off port b edge");
  a_space_sync: assert property ($changed(space_flag_n_o) || $changed(high_fill_flag_n_o)
    |-> $past(a_r) || $past(a_r, 2)) else $error("a flag off port a edge");
  c_a_to_b_mailbox_flag_n: cover property ($fell(a_to_b_mailbox_flag_n_o));
  c_full: cover property ($fell(space_flag_n_o));
  c_high: cover property ($fell(high_fill_flag_n_o));
endmodule // fpbfm_top_sva

bind fpbfm_top fpbfm_top_sva fpbfm_top_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .port_a_clock_i, .port_a_select_n_i,
  .port_a_write_not_read_i, .port_a_enable_i, .port_a_mailbox_sel_i, .port_b_clock_i,
  .port_b_select_n_i, .port_b_write_not_read_i, .port_b_enable_i, .port_b_size_sel_lo_i,
  .port_b_size_sel_hi_i, .port_b_data_oe_n_o, .space_flag_n_o, .data_avail_flag_n_o,
  .low_fill_flag_n_o, .high_fill_flag_n_o, .a_to_b_mailbox_flag_n_o,
  .b_to_a_mailbox_flag_n_o);

// ==== verif/fpbfm_top_tb.sv ====
`timescale 1ns/1ps
`include "fpbfm_defs.vh"
module fpbfm_top_tb;
  reg clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0, s;
  reg port_a_select_n_i = 1'b1, port_a_write_not_read_i = 1'b0, port_a_enable_i = 1'b0;
  reg port_a_mailbox_sel_i = 1'b0, port_b_select_n_i = 1'b1, port_b_write_not_read_i = 1'b0;
  reg port_b_enable_i = 1'b0, port_b_size_sel_lo_i = 1'b0, port_b_size_sel_hi_i = 1'b0;
  reg big_endian_sel_n_i = 1'b1, offset_sel_lo_i = 1'b0, offset_sel_hi_i = 1'b0;
  reg [35:0] port_a_data_i = 36'h0, port_b_data_i = 36'h0, rd;
  reg a_q = 1'b0, b_q = 1'b0;
  reg [1:0] idle_sz = 2'b00;
  wire [31:0] wb_dat_o;
  wire [35:0] port_a_data_o, port_b_data_o;
  wire wb_ack_o, port_a_clock_i, port_b_clock_i, port_a_data_oe_n_o, port_b_data_oe_n_o;
  wire space_flag_n_o, data_avail_flag_n_o, low_fill_flag_n_o, high_fill_flag_n_o;
  wire a_to_b_mailbox_flag_n_o, b_to_a_mailbox_flag_n_o;
  integer fails = 0, comparisons = 0, i;
  fpbfm_port_model fpbfm_port_model_inst (.clk_i, .port_a_clock_o(port_a_clock_i),
    .port_b_clock_o(port_b_clock_i));
  fpbfm_top fpbfm_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_a_clock_i, .port_a_select_n_i,
    .port_a_write_not_read_i, .port_a_enable_i, .port_a_mailbox_sel_i, .port_a_data_i,
    .port_a_data_o, .port_a_data_oe_n_o, .port_b_clock_i, .port_b_select_n_i,
    .port_b_write_not_read_i, .port_b_enable_i, .port_b_size_sel_lo_i, .port_b_size_sel_hi_i,
    .big_endian_sel_n_i, .port_b_data_i, .port_b_data_o, .port_b_data_oe_n_o,
    .offset_sel_lo_i, .offset_sel_hi_i, .space_flag_n_o, .data_avail_flag_n_o,
    .low_fill_flag_n_o, .high_fill_flag_n_o, .a_to_b_mailbox_flag_n_o,
    .b_to_a_mailbox_flag_n_o);
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    a_q <= port_a_clock_i;
    b_q <= port_b_clock_i;
  end
  // =====================================================================
  // tasks
  task check(input [95:0] nm, input [35:0] seen, input [35:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      if (fails == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // waits, bounded, for the given port pin (1 = port b) or the ack
  task wait_for(input [1:0] w);
    integer k;
    begin
      k = 0;
      @(posedge clk_i);
      while (!(w == 2'd2 ? wb_ack_o === 1'b1 : w[0] ? (b_q && !port_b_clock_i)
          : (a_q && !port_a_clock_i))) begin
        k = k + 1;
        if (k > 40) begin
          fails = fails + 1;
          results;
        end
        @(posedge clk_i);
      end
    end
  endtask
  // controls span a whole port period between two falling pin edges
  task a_op(input wnr, input mb, input [35:0] d);
    begin
      wait_for(2'd0);
      port_a_select_n_i <= 1'b0;
      port_a_write_not_read_i <= wnr;
      port_a_enable_i <= 1'b1;
      port_a_mailbox_sel_i <= mb;
      port_a_data_i <= d;
      wait_for(2'd0);
      port_a_select_n_i <= 1'b1;
      port_a_enable_i <= 1'b0;
      port_a_data_i <= ~d;
    end
  endtask
  task b_op(input wnr, input en, input [1:0] sz, input [35:0] d);
    begin
      wait_for(2'd1);
      port_b_select_n_i <= 1'b0;
      port_b_write_not_read_i <= wnr;
      port_b_enable_i <= en;
      {port_b_size_sel_hi_i, port_b_size_sel_lo_i} <= sz;
      port_b_data_i <= d;
      wait_for(2'd1);
      rd = port_b_data_o;
      check("b_drive", {35'h0, port_b_data_oe_n_o}, {35'h0, wnr});
      port_b_select_n_i <= 1'b1;
      port_b_enable_i <= 1'b0;
      {port_b_size_sel_hi_i, port_b_size_sel_lo_i} <= idle_sz;
      port_b_data_i <= ~d;
    end
  endtask
  task wb(input we, input [3:0] a);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {32{we}};
      wait_for(2'd2);
      s = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  // =====================================================================
  // sequence
  initial begin
    for (i = 3; i >= 0; i = i - 1) begin
      @(posedge clk_i);
      rst_i <= 1'b1;
      {offset_sel_hi_i, offset_sel_lo_i} <= i[1:0];
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      check("reset", {port_b_data_oe_n_o, space_flag_n_o, data_avail_flag_n_o,
        low_fill_flag_n_o, high_fill_flag_n_o, a_to_b_mailbox_flag_n_o,
        b_to_a_mailbox_flag_n_o}, 36'h47);
      repeat (16) @(posedge clk_i);
      check("space_up", {35'h0, space_flag_n_o}, 36'h1);
      wb(1'b0, `FPBFM_REG_STATUS);
      check("offset", {31'h0, s[12:8]}, 4 + 4 * i);
    end
    wb(1'b1, 4'hc);
    wb(1'b0, 4'hc);
    check("unmapped", {4'h0, s}, 36'h0);
    a_op(1'b1, 1'b1, 36'h9abcdef01);
    a_op(1'b1, 1'b1, 36'h123456789);
    check("a_to_b_mailbox_flag_n_low", {35'h0, a_to_b_mailbox_flag_n_o}, 36'h0);
    b_op(1'b0, 1'b1, 2'b11, 36'h0);
    check("a_to_b_mailbox", rd, 36'h9abcdef01);
    check("a_to_b_mailbox_flag_n_set", {35'h0, a_to_b_mailbox_flag_n_o}, 36'h1);
    b_op(1'b0, 1'b1, 2'b11, 36'h0);
    check("a_to_b_mailbox_keep", rd, 36'h9abcdef01);
    b_op(1'b1, 1'b1, 2'b11, 36'h5a5a5a5a5);
    b_op(1'b1, 1'b1, 2'b11, 36'h0f0f0f0f0);
    check("b_to_a_mailbox_flag_n_low", {35'h0, b_to_a_mailbox_flag_n_o}, 36'h0);
    a_op(1'b0, 1'b1, 36'h0);
    check("b_to_a_mailbox", port_a_data_o, 36'h5a5a5a5a5);
    check("b_to_a_mailbox_flag_n_set", {35'h0, b_to_a_mailbox_flag_n_o}, 36'h1);
    for (i = 0; i < 64; i = i + 1) begin
      a_op(1'b1, 1'b0, 36'h100 + i);
      if (i == 3 || i == 4) begin
        repeat (20) @(posedge clk_i);
        check("low_fill", {35'h0, low_fill_flag_n_o}, i == 4);
        check("avail", {35'h0, data_avail_flag_n_o}, 36'h1);
      end
    end
    repeat (12) @(posedge clk_i);
    check("full", {34'h0, space_flag_n_o, high_fill_flag_n_o}, 36'h0);
    a_op(1'b1, 1'b0, 36'hdead);
    b_op(1'b1, 1'b1, 2'b00, 36'h0);
    check("idle_b", {35'h0, b_to_a_mailbox_flag_n_o}, 36'h1);
    for (i = 0; i < 64; i = i + 1) begin
      b_op(1'b0, 1'b1, 2'b00, 36'h0);
      check("fifo_data", rd, 36'h100 + i);
      repeat (12) @(posedge clk_i);
      if (i == 0)
        check("space_free", {35'h0, space_flag_n_o}, 36'h1);
      if (i == 3 || i == 4)
        check("high_fill", {35'h0, high_fill_flag_n_o}, i == 4);
    end
    check("empty", {34'h0, data_avail_flag_n_o, low_fill_flag_n_o}, 36'h0);
    b_op(1'b0, 1'b1, 2'b00, 36'h0);
    check("empty_read", rd, 36'h13f);
    a_op(1'b1, 1'b0, 36'h987654321);
    // let the data-available flag pass its two port b edges first
    repeat (16) @(posedge clk_i);
    idle_sz = 2'b10;
    b_op(1'b0, 1'b0, 2'b10, 36'h0);
    b_op(1'b0, 1'b1, 2'b10, 36'h0);
    check("word_lo", {18'h0, rd[17:0]}, 36'h014321);
    b_op(1'b0, 1'b1, 2'b10, 36'h0);
    check("word_hi", {18'h0, rd[17:0]}, 36'h261d9);
    results;
  end
endmodule // fpbfm_top_tb
